// ===== design/acq_defines.svh
`ifndef ACQ_DEFINES_SVH
`define ACQ_DEFINES_SVH
// counter and field widths
`define ACQ_CNT_W       16
`define ACQ_CHN_W       8
`define ACQ_CFG_W       14
// register byte offsets
`define ACQ_OFS_CMD     8'h00
`define ACQ_OFS_CFG     8'h04
`define ACQ_OFS_STATUS  8'h08
`define ACQ_OFS_CONVDIV 8'h0C
`define ACQ_OFS_CONVDLY 8'h10
`define ACQ_OFS_SCANDIV 8'h14
`define ACQ_OFS_SCANDLY 8'h18
`define ACQ_OFS_CHANCNT 8'h1C
`define ACQ_OFS_SCANCNT 8'h20
`define ACQ_OFS_STBDIV  8'h24
`define ACQ_OFS_SAMPLFT 8'h28
// command bits (write only, self clearing)
`define ACQ_CMD_START   0
`define ACQ_CMD_STOP    1
// status bits, overrun cleared by writing one
`define ACQ_STS_OVERRUN 0
`define ACQ_STS_INSCAN  1
`define ACQ_STS_ARMED   2
`define ACQ_STS_ACTIVE  3
// reset values
`define ACQ_RST_CFG     14'h0000
`define ACQ_RST_CONVDIV 16'h0004
`define ACQ_RST_CONVDLY 16'h0003
`define ACQ_RST_SCANDIV 16'h0010
`define ACQ_RST_SCANDLY 16'h0002
`define ACQ_RST_CHANCNT 8'h01
`define ACQ_RST_SCANCNT 16'h0001
`define ACQ_RST_STBDIV  16'h0001
`endif

// ===== design/acq_pkg.sv
`include "acq_defines.svh"
package acq_pkg;
    typedef logic [`ACQ_CNT_W-1:0] cnt_t;
    typedef logic [`ACQ_CHN_W-1:0] chn_t;
    // engine states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN   = 2'b10
    } eng_state_e;
    // begin trigger source
    typedef enum logic [1:0] {
        TRIG_SOFT    = 2'b00,
        TRIG_DIGITAL = 2'b01,
        TRIG_ANALOG  = 2'b10
    } trig_src_e;
    // configuration word, last member at bit 0
    typedef struct packed {
        logic      conv_ext;
        logic      conv_fall;
        logic      scan_ext;
        logic      scan_fall;
        trig_src_e trig_src;
        logic      trig_fall;
        logic      continuous;
        logic      retrig;
        logic      conv_tb_fast;
        logic      hold_pol;
        logic      hold_lvl;
        logic      stop_en;
        logic      stop_fall;
    } cfg_s;
    // previous levels of the edge sensitive inputs
    typedef struct packed {
        logic conv;
        logic scan;
        logic trig;
        logic cmp;
        logic stop;
    } pins_s;
endpackage : acq_pkg

// ===== design/acq_scan_conversion_timing_engine.sv
// Summary of operation
// - each accepted conversion pulse starts one conversion
// - conversion edge selectable rising or falling
// - down-counter from scan pulse emits conversions, reloads
// - first conversion delayed, default three ticks
// - conversion pulse driven out active low
// - pulses ignored until begin trigger accepted
// - conversions ignored before a scan pulse
// - extra conversions ignored until next scan
// - early scan pulse raises scan overrun
// - conversion timebase: scan timebase or fast tick
// - hold-done pulse after each conversion begins
// - hold-done polarity set by software
// - begin on trigger, or software command
// - end on count or stop trigger in finite mode, or command
// - retriggerable: full set per begin trigger
// - triggers ignored while generating, then rearm if retriggerable
// - stop trigger honoured once per finite acquisition
// - digital begin trigger edge selectable
// - analog begin on rising comparison edge
// - begin trigger driven out active high
// - first scan delayed, default two ticks
// - sample counter counts scans down to zero
// - hold trigger level halts scan generator
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ns
`include "acq_defines.svh"
module acq_scan_conversion_timing_engine
    import acq_pkg::*;
(
    input  wire logic        MCLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        EXT_CONV_IN,
    input  wire logic        EXT_SCAN_IN,
    input  wire logic        BEGIN_TRIG_IN,
    input  wire logic        CMP_EVENT_IN,
    input  wire logic        STOP_TRIG_IN,
    input  wire logic        HOLD_TRIG_IN,
    input  wire logic        FAST_TB_TICK_IN,
    output logic             ADC_CONV_OUT,
    output logic             CONV_PULSE_N_OUT,
    output logic             HOLD_DONE_OUT,
    output logic             BEGIN_TRIG_OUT,
    output logic             SCAN_PULSE_OUT
);

////////////////////////////////////////////////////////////
// helpers

// edge of a synchronous input against its previous level
function automatic logic edge_hit(input logic cur, input logic prv,
                                  input logic fall);
    edge_hit = fall ? (prv & ~cur) : (cur & ~prv);
endfunction : edge_hit

// address decode for the error answer; the read mux decodes the address itself
function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `ACQ_OFS_SAMPLFT);
endfunction : mapped

////////////////////////////////////////////////////////////
// register file over apb

cfg_s        cfg, next_cfg;           // mode bits
cnt_t        conv_div, next_conv_div; // conversion period
cnt_t        conv_dly, next_conv_dly; // scan to first conversion
cnt_t        scan_div, next_scan_div; // scan period
cnt_t        scan_dly, next_scan_dly; // trigger to first scan
chn_t        chan_cnt, next_chan_cnt; // conversions per scan
cnt_t        scan_cnt, next_scan_cnt; // scans per acquisition
cnt_t        stb_div, next_stb_div;   // scan timebase divider
logic        pready, next_pready;
logic        pslverr, next_pslverr;
logic [31:0] prdata, next_prdata;
logic        wr, cmd_start, cmd_stop, clr_ovr;

// engine state read back by software
eng_state_e  st;
logic        armed, in_scan, overrun;
cnt_t        samp_left;

// one wait state: pready rises in the second access cycle
always_comb
begin
    next_cfg      = cfg;
    next_conv_div = conv_div;
    next_conv_dly = conv_dly;
    next_scan_div = scan_div;
    next_scan_dly = scan_dly;
    next_chan_cnt = chan_cnt;
    next_scan_cnt = scan_cnt;
    next_stb_div  = stb_div;
    next_prdata   = prdata;
    next_pslverr  = pslverr;
    next_pready   = PSEL_IN & PENABLE_IN & ~pready;
    wr = PSEL_IN & PENABLE_IN & pready & PWRITE_IN;
    cmd_start = 1'b0;
    cmd_stop  = 1'b0;
    clr_ovr   = 1'b0;
    if (PSEL_IN && PENABLE_IN && !pready)
    begin
        // answer registered on the same edge as pready
        next_pslverr = ~mapped(PADDR_IN);
        next_prdata  = 32'h0000_0000;
        if (!PWRITE_IN)
        begin
            case (PADDR_IN)
                `ACQ_OFS_CFG:     next_prdata[`ACQ_CFG_W-1:0] = cfg;
                `ACQ_OFS_STATUS:
                begin
                    next_prdata[`ACQ_STS_OVERRUN] = overrun;
                    next_prdata[`ACQ_STS_INSCAN]  = in_scan;
                    next_prdata[`ACQ_STS_ARMED]   = armed;
                    next_prdata[`ACQ_STS_ACTIVE]  = (st != ST_IDLE);
                end
                `ACQ_OFS_CONVDIV: next_prdata[`ACQ_CNT_W-1:0] = conv_div;
                `ACQ_OFS_CONVDLY: next_prdata[`ACQ_CNT_W-1:0] = conv_dly;
                `ACQ_OFS_SCANDIV: next_prdata[`ACQ_CNT_W-1:0] = scan_div;
                `ACQ_OFS_SCANDLY: next_prdata[`ACQ_CNT_W-1:0] = scan_dly;
                `ACQ_OFS_CHANCNT: next_prdata[`ACQ_CHN_W-1:0] = chan_cnt;
                `ACQ_OFS_SCANCNT: next_prdata[`ACQ_CNT_W-1:0] = scan_cnt;
                `ACQ_OFS_STBDIV:  next_prdata[`ACQ_CNT_W-1:0] = stb_div;
                `ACQ_OFS_SAMPLFT: next_prdata[`ACQ_CNT_W-1:0] = samp_left;
                default:          next_prdata = 32'h0000_0000; // cmd reads zero
            endcase
        end
    end
    if (wr)
    begin
        case (PADDR_IN)
            `ACQ_OFS_CMD:
            begin
                cmd_start = PWDATA_IN[`ACQ_CMD_START];
                cmd_stop  = PWDATA_IN[`ACQ_CMD_STOP];
            end
            `ACQ_OFS_CFG:     next_cfg = cfg_s'(PWDATA_IN[`ACQ_CFG_W-1:0]);
            `ACQ_OFS_STATUS:  clr_ovr = PWDATA_IN[`ACQ_STS_OVERRUN];
            `ACQ_OFS_CONVDIV: next_conv_div = PWDATA_IN[`ACQ_CNT_W-1:0];
            `ACQ_OFS_CONVDLY: next_conv_dly = PWDATA_IN[`ACQ_CNT_W-1:0];
            `ACQ_OFS_SCANDIV: next_scan_div = PWDATA_IN[`ACQ_CNT_W-1:0];
            `ACQ_OFS_SCANDLY: next_scan_dly = PWDATA_IN[`ACQ_CNT_W-1:0];
            `ACQ_OFS_CHANCNT: next_chan_cnt = PWDATA_IN[`ACQ_CHN_W-1:0];
            `ACQ_OFS_SCANCNT: next_scan_cnt = PWDATA_IN[`ACQ_CNT_W-1:0];
            `ACQ_OFS_STBDIV:  next_stb_div = PWDATA_IN[`ACQ_CNT_W-1:0];
            default:          next_cfg = cfg; // read-only or unmapped
        endcase
    end
end

// register stage of the bus group
always_ff @(posedge MCLK_IN)
begin
    if (!RST_N_IN)
    begin
        cfg      <= cfg_s'(`ACQ_RST_CFG);
        conv_div <= `ACQ_RST_CONVDIV;
        conv_dly <= `ACQ_RST_CONVDLY;
        scan_div <= `ACQ_RST_SCANDIV;
        scan_dly <= `ACQ_RST_SCANDLY;
        chan_cnt <= `ACQ_RST_CHANCNT;
        scan_cnt <= `ACQ_RST_SCANCNT;
        stb_div  <= `ACQ_RST_STBDIV;
        pready   <= 1'b0;
        pslverr  <= 1'b0;
        prdata   <= 32'h0000_0000;
    end
    else
    begin
        cfg      <= next_cfg;
        conv_div <= next_conv_div;
        conv_dly <= next_conv_dly;
        scan_div <= next_scan_div;
        scan_dly <= next_scan_dly;
        chan_cnt <= next_chan_cnt;
        scan_cnt <= next_scan_cnt;
        stb_div  <= next_stb_div;
        pready   <= next_pready;
        pslverr  <= next_pslverr;
        prdata   <= next_prdata;
    end
end

assign PREADY_OUT  = pready;
assign PSLVERR_OUT = pslverr;
assign PRDATA_OUT  = prdata;

////////////////////////////////////////////////////////////
// timing engine

eng_state_e next_st;
logic       next_armed, next_in_scan, next_overrun;
cnt_t       next_samp_left;
cnt_t       stb_cnt, next_stb_cnt;     // scan timebase divider
cnt_t       scan_tmr, next_scan_tmr;   // scan pulse down-counter
cnt_t       conv_tmr, next_conv_tmr;   // conversion down-counter
chn_t       conv_left, next_conv_left; // conversions still owed
logic       stop_used, next_stop_used;
pins_s      prv, next_prv;
logic       conv_o, hold_o, begin_o, scan_o, convn_o;
logic       next_hold_o;
// combinational events
logic       stb_tick, conv_tick, hold_act, trig_hit, trig_ok;
logic       scan_req, scan_ok, conv_req, conv_fire, stop_ok, acq_end;
logic       set_ovr;

always_comb
begin
    next_st        = st;
    next_armed     = armed;
    next_in_scan   = in_scan;
    next_samp_left = samp_left;
    next_scan_tmr  = scan_tmr;
    next_conv_tmr  = conv_tmr;
    next_conv_left = conv_left;
    next_stop_used = stop_used;
    next_prv       = '{EXT_CONV_IN, EXT_SCAN_IN, BEGIN_TRIG_IN,
                       CMP_EVENT_IN, STOP_TRIG_IN};
    trig_ok   = 1'b0;
    scan_req  = 1'b0;
    conv_req  = 1'b0;
    conv_fire = 1'b0;
    stop_ok   = 1'b0;
    acq_end   = 1'b0;
    set_ovr   = 1'b0;
    // scan timebase: system clock divided, zero treated as one
    stb_tick     = (stb_cnt <= 16'h0001);
    next_stb_cnt = stb_tick ? stb_div : stb_cnt - 16'h0001;
    conv_tick = cfg.conv_tb_fast ? FAST_TB_TICK_IN : stb_tick;
    hold_act  = (HOLD_TRIG_IN == cfg.hold_lvl);
    // begin trigger source select
    case (cfg.trig_src)
        TRIG_SOFT:    trig_hit = cmd_start;
        TRIG_DIGITAL: trig_hit = edge_hit(BEGIN_TRIG_IN, prv.trig,
                                          cfg.trig_fall);
        TRIG_ANALOG:  trig_hit = CMP_EVENT_IN & ~prv.cmp;
        default:      trig_hit = 1'b0;
    endcase
    case (st)
        ST_IDLE:
        begin
            // only idle listens, so a busy engine ignores triggers
            if ((armed || cmd_start) && trig_hit)
            begin
                trig_ok        = 1'b1;
                next_stop_used = 1'b0;
                next_samp_left = scan_cnt;
                next_conv_tmr  = conv_dly;
                next_scan_tmr  = scan_dly;
                next_st = cfg.scan_ext ? ST_RUN : ST_DELAY;
            end
        end
        ST_DELAY, ST_RUN: // scans heard only after a begin trigger
        begin
            if (cfg.scan_ext)
                scan_req = edge_hit(EXT_SCAN_IN, prv.scan, cfg.scan_fall);
            else if (stb_tick && !hold_act) // generator halts on hold
            begin
                if (scan_tmr <= 16'h0001)
                begin
                    scan_req      = 1'b1;
                    next_scan_tmr = scan_div;
                    next_st       = ST_RUN;
                end
                else
                    next_scan_tmr = scan_tmr - 16'h0001;
            end
        end
        default: next_st = ST_IDLE;
    endcase
    // finite mode refuses scans once the count is spent
    scan_ok = scan_req && (cfg.continuous || samp_left != 16'h0000);
    if (scan_ok)
    begin
        set_ovr        = in_scan && conv_left != 8'h00;
        next_in_scan   = 1'b1;
        next_conv_left = chan_cnt;
        next_conv_tmr  = conv_dly;
        if (!cfg.continuous)
            next_samp_left = samp_left - 16'h0001;
    end
    else if (in_scan && conv_left != 8'h00)
    begin
        if (cfg.conv_ext)
            conv_req = edge_hit(EXT_CONV_IN, prv.conv, cfg.conv_fall);
        else if (conv_tick)
        begin
            conv_req      = (conv_tmr <= 16'h0001);
            next_conv_tmr = conv_tmr - 16'h0001;
        end
        if (conv_req)
        begin
            conv_fire      = 1'b1;
            next_conv_left = conv_left - 8'h01;
            // reload the period, or the delay when the scan is done
            next_conv_tmr  = (conv_left == 8'h01) ? conv_dly : conv_div;
            next_in_scan   = (conv_left != 8'h01);
        end
    end
    // acquisition end conditions
    if (st != ST_IDLE)
    begin
        stop_ok = !cfg.continuous && cfg.stop_en && !stop_used &&
                  edge_hit(STOP_TRIG_IN, prv.stop, cfg.stop_fall);
        acq_end = cmd_stop || stop_ok ||
                  (!cfg.continuous && st == ST_RUN && !in_scan &&
                   samp_left == 16'h0000);
    end
    if (stop_ok)
        next_stop_used = 1'b1;
    if (acq_end)
    begin
        next_st      = ST_IDLE;
        next_in_scan = 1'b0;
        next_armed   = cfg.retrig && armed; // stay armed for next trigger only when retrig is set
    end
    if (cmd_start)
        next_armed = 1'b1;
    next_overrun = set_ovr | (overrun & ~clr_ovr); // set beats clear
    next_hold_o  = conv_o ^ cfg.hold_pol;
end

// register stage of the engine group
always_ff @(posedge MCLK_IN)
begin
    if (!RST_N_IN)
    begin
        st        <= ST_IDLE;
        armed     <= 1'b0;
        in_scan   <= 1'b0;
        overrun   <= 1'b0;
        samp_left <= 16'h0000;
        stb_cnt   <= 16'h0000;
        scan_tmr  <= 16'h0000;
        conv_tmr  <= 16'h0000;
        conv_left <= 8'h00;
        stop_used <= 1'b0;
        prv       <= 5'h00;
        conv_o    <= 1'b0;
        convn_o   <= 1'b1;
        hold_o    <= 1'b0;
        begin_o   <= 1'b0;
        scan_o    <= 1'b0;
    end
    else
    begin
        st        <= next_st;
        armed     <= next_armed;
        in_scan   <= next_in_scan;
        overrun   <= next_overrun;
        samp_left <= next_samp_left;
        stb_cnt   <= next_stb_cnt;
        scan_tmr  <= next_scan_tmr;
        conv_tmr  <= next_conv_tmr;
        conv_left <= next_conv_left;
        stop_used <= next_stop_used;
        prv       <= next_prv;
        conv_o    <= conv_fire;
        convn_o   <= ~conv_fire;
        hold_o    <= next_hold_o;
        begin_o   <= trig_ok;
        scan_o    <= scan_ok;
    end
end

assign ADC_CONV_OUT     = conv_o;
assign CONV_PULSE_N_OUT = convn_o;
assign HOLD_DONE_OUT    = hold_o;
assign BEGIN_TRIG_OUT   = begin_o;
assign SCAN_PULSE_OUT   = scan_o;

////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge MCLK_IN); endclocking
default disable iff (!RST_N_IN);

sequence scan_while_busy;
    scan_ok && in_scan && conv_left != 8'h00;
endsequence

sequence gen_halted;
    hold_act && st != ST_IDLE && !cfg.scan_ext;
endsequence

chk_idle_gates_conv: assert property (
    ADC_CONV_OUT |-> $past(st) != ST_IDLE)
    else $error("conversion while no acquisition");

chk_conv_needs_scan: assert property (
    ADC_CONV_OUT |-> $past(in_scan) && $past(scan_o || in_scan))
    else $error("conversion before scan pulse");

chk_conv_count: assert property (
    ADC_CONV_OUT |-> $past(conv_left) != 8'h00 &&
                     conv_left == $past(conv_left) - 8'h01)
    else $error("conversion beyond channel count");

chk_overrun_flag: assert property (
    scan_while_busy |=> overrun [*2])
    else $error("scan overrun not flagged");

chk_conv_low: assert property (
    $fell(CONV_PULSE_N_OUT) |-> ADC_CONV_OUT ##1 CONV_PULSE_N_OUT ||
                                ADC_CONV_OUT)
    else $error("conversion output not active low");

chk_hold_after_conv: assert property (
    ADC_CONV_OUT && $stable(cfg) |=> HOLD_DONE_OUT != cfg.hold_pol)
    else $error("hold done missing after conversion");

chk_busy_no_trig: assert property (
    st != ST_IDLE && !acq_end |=> !BEGIN_TRIG_OUT)
    else $error("begin trigger taken while busy");

chk_stop_once: assert property (
    stop_ok |-> !stop_used ##1 st == ST_IDLE && stop_used)
    else $error("stop trigger not honoured once");

chk_hold_halts: assert property (
    gen_halted |=> $stable(scan_tmr) && !SCAN_PULSE_OUT)
    else $error("scan generator ran while held");

chk_first_conv_gap: assert property (
    scan_ok && !cfg.conv_ext && conv_dly > 16'h0001 |=> !conv_fire)
    else $error("first conversion came too early");

endmodule : acq_scan_conversion_timing_engine

// ===== sim/acq_src_model.sv
`timescale 1ns/1ns
// far side: trigger and clock sources, plus the converter that counts starts
module acq_src_model
(
    input  wire logic       clk_in,
    input  wire logic       adc_conv_in,
    output logic      [4:0] pins_out,
    output logic            hold_out,
    output logic            tick_out
);
    int         n_conv;   // conversions seen by the converter
    logic [1:0] div;      // fast tick divider
    ////////////////////////////////////////////////////////////////
    initial
    begin
        pins_out = 5'h00;
        hold_out = 1'b0;
        tick_out = 1'b0;
        n_conv   = 0;
        div      = 2'h0;
    end
    // fast tick every third clock, so fast and scan timebases differ
    always @(posedge clk_in)
    begin
        div      <= (div == 2'h2) ? 2'h0 : div + 2'h1;
        tick_out <= (div == 2'h2);
        if (adc_conv_in === 1'b1)
            n_conv++;
    end
    // one rising then one falling edge, so either polarity sees one hit
    task pulse(input int i);
        @(posedge clk_in);
        pins_out[i] <= 1'b1;
        repeat (2) @(posedge clk_in);
        pins_out[i] <= 1'b0;
        // third edge lets the monitors count the answer before the caller looks
        repeat (3) @(posedge clk_in);
    endtask : pulse
    // hold trigger level, changed just after a clock edge
    task hold(input logic v);
        @(posedge clk_in);
        hold_out <= v;
    endtask : hold
endmodule : acq_src_model

// ===== sim/test_acq_scan_conversion_timing_engine.sv
`timescale 1ns/1ns
module test_acq_scan_conversion_timing_engine
    import acq_pkg::*;
;
    logic        clk, rst_n, psel, pen, pwr, hpol, pa;
    logic [7:0]  paddr;
    logic [31:0] pwdata, q;
    logic        e;
    wire  [31:0] prdata;
    wire         pready, pslverr, adc, cpn, hold, bto, sco, htrig, tick;
    wire  [4:0]  src;
    int n_mismatch, n_checks, seed, cyc, n_beg, n_scan, n_hold, n_cpn;
    int t_beg, t_scan, a0, b0, s0, h0, c0, cb, ch, sc, dv, fast, hp;
    int qa[$];                                      // conversion stamps
    logic [7:0] ofs [9] = '{8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h2C};
    int         rv [9]  = '{0, 4, 3, 16, 2, 1, 1, 1, 0};
    ////////////////////////////////////////////////////////////////
    acq_scan_conversion_timing_engine DUT (.MCLK_IN(clk), .RST_N_IN(rst_n),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .EXT_CONV_IN(src[0]), .EXT_SCAN_IN(src[1]),
        .BEGIN_TRIG_IN(src[2]), .CMP_EVENT_IN(src[3]), .STOP_TRIG_IN(src[4]),
        .HOLD_TRIG_IN(htrig), .FAST_TB_TICK_IN(tick), .ADC_CONV_OUT(adc),
        .CONV_PULSE_N_OUT(cpn), .HOLD_DONE_OUT(hold), .BEGIN_TRIG_OUT(bto),
        .SCAN_PULSE_OUT(sco));
    acq_src_model src_m (.clk_in(clk), .adc_conv_in(adc), .pins_out(src),
        .hold_out(htrig), .tick_out(tick));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    // setup, access, hold until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rq, output logic re);
        int k;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask : wr
    // poll the active status bit, bounded
    task wait_idle;
        int k;
        k = 0;
        do
        begin
            apb(1'b0, 8'h08, 32'h0, q, e);
            k++;
        end while (q[3] !== 1'b0 && k < 300);
    endtask : wait_idle
    // scan spacing long enough for every conversion of one scan
    function int scan_gap(input int c, input int d, input int f);
        return (3 + c * d) * (f != 0 ? 3 : 1) + 8;
    endfunction : scan_gap
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////
    // output monitor: counts and stamps, hold follows each conversion
    always @(posedge clk)
    begin
        cyc++;
        if (pa)
            chk(hold, !hpol);
        pa = (adc === 1'b1);
        if (bto === 1'b1)
        begin
            n_beg++;
            t_beg = cyc;
        end
        if (sco === 1'b1)
        begin
            n_scan++;
            t_scan = cyc;
        end
        if (pa)
            qa.push_back(cyc);
        if (cpn === 1'b0)
            n_cpn++;
        if (hold !== hpol)
            n_hold++;
    end
    // watchdog, far beyond the expected run
    initial
    begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        {n_mismatch, n_checks, cyc, n_beg, n_scan, n_hold, n_cpn} = '0;
        seed = 32'hBC50;
        {rst_n, psel, pen, pwr, hpol, pa, paddr, pwdata} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // reset values, last entry is an unmapped word
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b0, ofs[i], 32'h0, q, e);
            chk(q, rv[i]);
            chk(e, i == 8);
        end
        $display("test reset_values done");
        // default timing walk, soft start, two channels
        wr(8'h04, 32'h4);
        wr(8'h1C, 32'h2);
        qa.delete();
        b0 = n_beg;
        wr(8'h00, 32'h1);
        wait_idle();
        chk(n_beg - b0, 1);
        chk(t_scan - t_beg, 2);
        chk(qa[0] - t_scan, 3);
        chk(qa[1] - qa[0], 4);
        chk(qa.size(), 2);
        $display("test timing_walk done");
        // random channel, scan, divider, timebase and polarity mixes
        for (int r = 0; r < 6; r++)
        begin
            ch   = 1 + {$random(seed)} % 4;
            sc   = 1 + {$random(seed)} % 3;
            dv   = 1 + {$random(seed)} % 4;
            fast = (r < 2) ? r : $random(seed) & 1; // both timebases seen
            hp   = $random(seed) & 1;
            wr(8'h1C, ch);
            wr(8'h20, sc);
            wr(8'h0C, dv);
            wr(8'h14, scan_gap(ch, dv, fast));
            wr(8'h04, 32'h4 | (fast << 4) | (hp << 3));
            hpol = hp[0];
            wr(8'h00, 32'h1);
            // snapshot once the new hold polarity has reached the pin
            {a0, s0, h0, c0} = {src_m.n_conv, n_scan, n_hold, n_cpn};
            wait_idle();
            chk(src_m.n_conv - a0, ch * sc);
            chk(n_scan - s0, sc);
            chk(n_hold - h0, ch * sc);
            chk(n_cpn - c0, ch * sc);
            chk(hold, hpol);
        end
        $display("test random_scans done");
        // external scans and conversions, falling digital trigger
        hpol = 1'b0;
        wr(8'h04, 32'h2984);
        wr(8'h1C, 32'h2);
        wr(8'h20, 32'h5);
        {a0, b0, s0} = {src_m.n_conv, n_beg, n_scan};
        src_m.pulse(0);
        src_m.pulse(1);
        chk(src_m.n_conv - a0, 0);
        chk(n_scan - s0, 0);
        wr(8'h00, 32'h1);
        cb = cyc;
        src_m.pulse(2);
        chk(n_beg - b0, 1);
        chk(t_beg - cb > 4, 1);
        src_m.pulse(0);
        chk(src_m.n_conv - a0, 0);
        src_m.pulse(1);
        repeat (3) src_m.pulse(0);
        chk(src_m.n_conv - a0, 2);
        src_m.pulse(1);
        src_m.pulse(0);
        src_m.pulse(1);
        apb(1'b0, 8'h08, 32'h0, q, e);
        chk(q[0], 1);
        wr(8'h08, 32'h1);
        apb(1'b0, 8'h08, 32'h0, q, e);
        chk(q[0], 0);
        wr(8'h00, 32'h2);
        apb(1'b0, 8'h08, 32'h0, q, e);
        chk(q[3], 0);
        $display("test external_sources done");
        // retriggerable analog begin, second hit during generation ignored
        wr(8'h04, 32'h224);
        wr(8'h1C, 32'h1);
        wr(8'h20, 32'h2);
        wr(8'h14, 32'h10);
        {a0, b0} = {src_m.n_conv, n_beg};
        wr(8'h00, 32'h1);
        src_m.pulse(3);
        src_m.pulse(3);
        wait_idle();
        chk(n_beg - b0, 1);
        chk(src_m.n_conv - a0, 2);
        src_m.pulse(3);
        wait_idle();
        chk(n_beg - b0, 2);
        chk(src_m.n_conv - a0, 4);
        $display("test retrigger done");
        // hold level freezes the internal generator, release resumes it
        wr(8'h04, 32'h4);
        s0 = n_scan;
        src_m.hold(1'b1);
        wr(8'h00, 32'h1);
        repeat (40) @(posedge clk);
        chk(n_scan - s0, 0);
        src_m.hold(1'b0);
        wait_idle();
        chk(n_scan - s0, 2);
        $display("test hold_trigger done");
        // stop trigger ends a long finite acquisition at once
        wr(8'h04, 32'h6);
        wr(8'h20, 32'hC8);
        wr(8'h00, 32'h1);
        apb(1'b0, 8'h08, 32'h0, q, e);
        chk(q[3], 1);
        src_m.pulse(4);
        apb(1'b0, 8'h08, 32'h0, q, e);
        chk(q[3], 0);
        $display("test stop_trigger done");
        complete_run();
    end
endmodule : test_acq_scan_conversion_timing_engine
